// >>> rtl/pwl_params.svh
`ifndef PWL_PARAMS_SVH
`define PWL_PARAMS_SVH

// Number of guarded peripheral groups, one lock bit each.
`define PWL_NUM_GROUPS      16
`define PWL_GROUP_IDX_W     4
`define PWL_KEY_W           8
`define PWL_ADDR_W          12
`define PWL_DATA_W          32

// Key sequence values. Arbitrary, chosen to be unlikely as stray data.
`define PWL_KEY_FIRST       8'hA5
`define PWL_KEY_SECOND      8'hF1

// Reset values.
`define PWL_LOCK_RST        16'h0000
`define PWL_KEY_LOCKED      1'b1

`endif

// >>> rtl/pwl_pkg.sv
`default_nettype none
package pwl_pkg;

    typedef enum logic [2:0] {
        PWL_KEY_IDLE     = 3'b001,
        PWL_KEY_GOT_ONE  = 3'b010,
        PWL_KEY_UNLOCKED = 3'b100
    } pwl_key_state_e;

endpackage

`default_nettype wire

// >>> rtl/pwl_key_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwl_params.svh"

module pwl_key_seq
    import pwl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  key_wr_en,
    input  wire logic [`PWL_KEY_W-1:0] key_wr_data,
    output logic                       unlocked
);

    pwl_key_state_e state_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= PWL_KEY_IDLE;
        end
        else if (key_wr_en)
        begin
            unique case (state_q)
                PWL_KEY_IDLE:
                begin
                    if (key_wr_data == `PWL_KEY_FIRST)
                    begin
                        state_q <= PWL_KEY_GOT_ONE;
                    end
                end
                PWL_KEY_GOT_ONE:
                begin
                    // A wrong value restarts matching; a repeated first value counts as a fresh start.
                    if (key_wr_data == `PWL_KEY_SECOND)
                    begin
                        state_q <= PWL_KEY_UNLOCKED;
                    end
                    else if (key_wr_data == `PWL_KEY_FIRST)
                    begin
                        state_q <= PWL_KEY_GOT_ONE;
                    end
                    else
                    begin
                        state_q <= PWL_KEY_IDLE;
                    end
                end
                PWL_KEY_UNLOCKED:
                begin
                    state_q <= PWL_KEY_IDLE;
                end
                default:
                begin
                    state_q <= PWL_KEY_IDLE;
                end
            endcase
        end
    end

    assign unlocked = (state_q == PWL_KEY_UNLOCKED);

endmodule

`default_nettype wire

// >>> rtl/pwl_top.sv
// Operation
// - Each lock bit guards one peripheral group.
// - Lock bits change only after full key sequence.
// - Any later key write relocks lock bits.
// - Key status shows locked or unlocked state.
// - Writes to locked groups are dropped.
// - Reads pass regardless of lock state.
`timescale 1ns/1ps
`default_nettype none
`include "pwl_params.svh"

module pwl_top
    import pwl_pkg::*;
(
    // Clock and synchronous reset.
    input  wire logic                        clk,
    input  wire logic                        sys_rst,

    // Key register: writes step the sequencer, the status is what a read returns.
    input  wire logic                        key_wr_en,
    input  wire logic [`PWL_KEY_W-1:0]       key_wr_data,
    output logic                             key_status_locked,

    // Lock register: one bit per peripheral group.
    input  wire logic                        lock_wr_en,
    input  wire logic [`PWL_NUM_GROUPS-1:0]  lock_wr_data,
    output logic [`PWL_NUM_GROUPS-1:0]       peripheral_group_lock_bits,
    output logic                             lock_wr_refused,

    // Peripheral write path.
    input  wire logic                        periph_wr_en,
    input  wire logic [`PWL_GROUP_IDX_W-1:0] periph_wr_group,
    input  wire logic [`PWL_ADDR_W-1:0]      periph_wr_addr,
    input  wire logic [`PWL_DATA_W-1:0]      periph_wr_data,
    output logic [`PWL_NUM_GROUPS-1:0]       periph_grp_wr_en,
    output logic [`PWL_ADDR_W-1:0]           periph_fwd_wr_addr,
    output logic [`PWL_DATA_W-1:0]           periph_fwd_wr_data,
    output logic                             periph_wr_dropped,

    // Peripheral read path.
    input  wire logic                        periph_rd_en,
    input  wire logic [`PWL_GROUP_IDX_W-1:0] periph_rd_group,
    input  wire logic [`PWL_ADDR_W-1:0]      periph_rd_addr,
    output logic [`PWL_NUM_GROUPS-1:0]       periph_grp_rd_en,
    output logic [`PWL_ADDR_W-1:0]           periph_fwd_rd_addr
);

    logic                       unlocked;
    logic                       lock_wr_ok;
    logic [`PWL_NUM_GROUPS-1:0] lock_q;
    // Per-group hits of the incoming write and read, decoded once and shared.
    logic [`PWL_NUM_GROUPS-1:0] wr_hit;
    logic [`PWL_NUM_GROUPS-1:0] rd_hit;

    // The key matching lives in its own module so that its rules can be checked alone.
    // This module only needs to know whether the lock register is open.
    pwl_key_seq u_pwl_key_seq (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .key_wr_en   (key_wr_en),
        .key_wr_data (key_wr_data),
        .unlocked    (unlocked)
    );

    // A lock write in the same cycle as the relocking key write still lands,
    // because the key state only changes at the end of that cycle.
    always_comb
    begin
        // A write that arrives while the sequencer is not open is never taken.
        lock_wr_ok = 1'b0;
        if (lock_wr_en && unlocked)
        begin
            lock_wr_ok = 1'b1;
        end
    end

    // The status register is what a read of the key register returns. A key write always
    // reports locked on the next edge, because a write while unlocked relocks and a write that
    // completes the sequence only shows as unlocked one edge after the sequencer opens.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            key_status_locked <= `PWL_KEY_LOCKED;
        end
        else if (key_wr_en)
        begin
            // A key write forces the status to locked on the next edge, whatever the sequencer does.
            key_status_locked <= 1'b1;
        end
        else
        begin
            key_status_locked <= !unlocked;
        end
    end

    // A refused lock write leaves no trace in the lock bits.
    // This pulse lets the bus side flag it as an access error,
    // instead of the write failing silently.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lock_wr_refused <= 1'b0;
        end
        else
        begin
            lock_wr_refused <= lock_wr_en && !unlocked;
        end
    end

    // All groups come out of reset unlocked, so boot code can set up every
    // peripheral before it arms the locks. Once armed, only a full key
    // sequence opens the way to clear them again.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lock_q <= `PWL_LOCK_RST;
        end
        else if (lock_wr_ok)
        begin
            lock_q <= lock_wr_data;
        end
    end

    assign peripheral_group_lock_bits = lock_q;

    // Address and data are forwarded unconditionally; only the per-group write
    // strobes are gated, which keeps the data path free of lock logic.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            periph_fwd_wr_addr <= '0;
        end
        else
        begin
            periph_fwd_wr_addr <= periph_wr_addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            periph_fwd_wr_data <= '0;
        end
        else
        begin
            periph_fwd_wr_data <= periph_wr_data;
        end
    end

    // The read address moves even when no read is requested, so a peripheral
    // must qualify it with its own read strobe.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            periph_fwd_rd_addr <= '0;
        end
        else
        begin
            periph_fwd_rd_addr <= periph_rd_addr;
        end
    end

    // A dropped write is reported as a pulse while the peripheral never sees
    // its strobe, so its registers keep their contents.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            periph_wr_dropped <= 1'b0;
        end
        else
        begin
            periph_wr_dropped <= |(wr_hit & lock_q);
        end
    end

    // One cell per peripheral group: the decode, the gated write strobe and
    // the ungated read strobe of that group.
    genvar g;
    generate
        for (g = 0; g < `PWL_NUM_GROUPS; g = g + 1)
        begin : gen_grp
            assign wr_hit[g] = periph_wr_en && (periph_wr_group == g);
            assign rd_hit[g] = periph_rd_en && (periph_rd_group == g);

            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    periph_grp_wr_en[g] <= 1'b0;
                end
                else
                begin
                    // A lock bit written in this same cycle only guards later writes;
                    // this write is judged by the bits that stand now.
                    periph_grp_wr_en[g] <= wr_hit[g] && !lock_q[g];
                end
            end

            // Reads are never gated, so software can inspect a locked group.
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    periph_grp_rd_en[g] <= 1'b0;
                end
                else
                begin
                    periph_grp_rd_en[g] <= rd_hit[g];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> sim/pwl_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwl_params.svh"
module pwl_top_monitor
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        key_wr_en,
    input wire logic [7:0]  key_wr_data,
    input wire logic        key_status_locked,
    input wire logic        lock_wr_en,
    input wire logic [15:0] lock_wr_data,
    input wire logic [15:0] peripheral_group_lock_bits,
    input wire logic        lock_wr_refused,
    input wire logic        periph_wr_en,
    input wire logic [3:0]  periph_wr_group,
    input wire logic [15:0] periph_grp_wr_en,
    input wire logic        periph_wr_dropped,
    input wire logic        periph_rd_en,
    input wire logic [3:0]  periph_rd_group,
    input wire logic [15:0] periph_grp_rd_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Status lags the sequencer by one edge, so only a sequence started from a settled lock is judged.
    AST_UNLOCK: assert property (
        key_wr_en && key_wr_data == `PWL_KEY_FIRST && key_status_locked && !$past(key_wr_en) ##1
        key_wr_en && key_wr_data == `PWL_KEY_SECOND ##1 !key_wr_en |=> !key_status_locked)
        else $error("no unlock");
    AST_RELOCK: assert property (key_wr_en |=> key_status_locked)
        else $error("no relock");
    AST_TAKE: assert property (
        lock_wr_en && !key_status_locked |=> peripheral_group_lock_bits == $past(lock_wr_data))
        else $error("lock write lost");
    AST_REFUSE: assert property (
        lock_wr_en && key_status_locked && !$past(key_wr_en)
        |=> lock_wr_refused && $stable(peripheral_group_lock_bits))
        else $error("lock write taken");
    AST_DROP: assert property (
        periph_wr_en && peripheral_group_lock_bits[periph_wr_group]
        |=> periph_wr_dropped && periph_grp_wr_en == 16'h0000)
        else $error("write not dropped");
    AST_PASS: assert property (
        periph_wr_en && !peripheral_group_lock_bits[periph_wr_group]
        |=> periph_grp_wr_en == 16'h0001 << $past(periph_wr_group) && !periph_wr_dropped)
        else $error("write strobe wrong");
    AST_READ: assert property (
        periph_rd_en |=> periph_grp_rd_en == 16'h0001 << $past(periph_rd_group))
        else $error("read strobe wrong");
endmodule
bind pwl_top pwl_top_monitor u_mon (.*);
`default_nettype wire

// >>> sim/test_pwl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwl_params.svh"
module test_pwl_top;
    logic        clk = 0, sys_rst = 1, key_wr_en = 0, lock_wr_en = 0, periph_wr_en = 0, periph_rd_en = 0;
    logic        key_status_locked, lock_wr_refused, periph_wr_dropped;
    logic [7:0]  key_wr_data = 0;
    logic [3:0]  periph_wr_group = 0, periph_rd_group = 0;
    logic [11:0] periph_wr_addr = 0, periph_rd_addr = 0, periph_fwd_wr_addr, periph_fwd_rd_addr;
    logic [15:0] lock_wr_data = 0, peripheral_group_lock_bits, periph_grp_wr_en, periph_grp_rd_en, lk = 0;
    logic [31:0] periph_wr_data = 0, periph_fwd_wr_data, s = 10;
    logic [32:0] q[$];
    int          st = 0, errors = 0, check_count = 0, cyc = 0;
    pwl_top u_pwl_top (.*);
    always #20 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One cycle of random traffic; the model notes the pulses and updates its own lock state.
    task automatic step(input logic k, input logic [7:0] kd);
        logic es, rf;
        s = xs(s);
        {lock_wr_en, lock_wr_data, periph_wr_en, periph_wr_group, periph_rd_en, periph_rd_group} = s[26:0];
        {periph_wr_data, periph_wr_addr, periph_rd_addr} = {s, s[31:20], s[11:0]};
        {key_wr_en, key_wr_data} = {k, kd};
        es = k || st != 2;
        rf = lock_wr_en && st != 2;
        if (periph_wr_en || periph_rd_en)
            q.push_back({periph_wr_en & lk[periph_wr_group],
                periph_wr_en & !lk[periph_wr_group] ? 16'h0001 << periph_wr_group : 16'h0000,
                periph_rd_en ? 16'h0001 << periph_rd_group : 16'h0000});
        if (lock_wr_en && st == 2)
            lk = lock_wr_data;
        if (k)
            st = st == 2 ? 0 : kd == `PWL_KEY_FIRST ? 1 : st == 1 && kd == `PWL_KEY_SECOND ? 2 : 0;
        @(posedge clk);
        #1;
        chk("status", key_status_locked, es);
        chk("refused", lock_wr_refused, rf);
        chk("lock", peripheral_group_lock_bits, lk);
        chk("wr_addr", periph_fwd_wr_addr, periph_wr_addr);
        chk("wr_data", periph_fwd_wr_data, periph_wr_data);
        chk("rd_addr", periph_fwd_rd_addr, periph_rd_addr);
    endtask
    // Pulses are looked at mid-cycle, where they stand settled, one edge after their request.
    always @(negedge clk)
    begin
        if (!sys_rst && {periph_wr_dropped, periph_grp_wr_en, periph_grp_rd_en} !== 0)
            chk("pulse", {periph_wr_dropped, periph_grp_wr_en, periph_grp_rd_en},
                q.size() ? q.pop_front() : 33'h1_ffff_ffff);
        cyc++;
        if (cyc > 2000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 0;
        repeat (20) step(0, 8'h00);
        $display("test locked done");
        step(1, `PWL_KEY_FIRST);
        step(1, `PWL_KEY_SECOND);
        repeat (20) step(0, 8'h00);
        $display("test unlocked done");
        repeat (300)
        begin
            s = xs(s);
            step(s[1:0] == 0, s[3:2] == 0 ? s[15:8] : s[2] ? `PWL_KEY_SECOND : `PWL_KEY_FIRST);
        end
        {key_wr_en, lock_wr_en, periph_wr_en, periph_rd_en} = 4'h0;
        repeat (2) @(posedge clk);
        chk("queue", q.size(), 0);
        $display("test random done");
        summarize();
    end
endmodule
`default_nettype wire
